//--- src/event_filter.sv
// three-stage synchroniser with agreement filter for one event line
`timescale 1ns/10ps
module event_filter
(
    input wire logic CLK_SYS,
    input wire logic RST,
    event_sync_if.filter ev
);
    import sysctl_pkg::*;

    logic [SYNC_STAGES-1:0] stage_reg;
    logic [SYNC_STAGES-1:0] stage_next;
    logic level_reg;
    logic level_next;

    // shift chain; level moves only when last two stages agree
    always_comb
    begin
        stage_next = {stage_reg[SYNC_STAGES-2:0], ev.raw_level};
        level_next = level_reg;
        if (stage_reg[1] == stage_reg[2])
        begin
            level_next = stage_reg[2];
        end
    end

    // registers
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            stage_reg <= '0;
            level_reg <= 1'b0;
        end
        else
        begin
            stage_reg <= stage_next;
            level_reg <= level_next;
        end
    end

    assign ev.filtered = level_reg;
endmodule : event_filter

//--- src/event_sync_if.sv
// one event line travelling into its synchroniser and back out filtered
`timescale 1ns/10ps
interface event_sync_if;
    logic raw_level;
    logic filtered;
    modport filter (input raw_level, output filtered);
    modport user (output raw_level, input filtered);
endinterface : event_sync_if

//--- src/sysctl_pkg.sv
// constants for the peripheral reset and raw event status block
package sysctl_pkg;
    // bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int EVENT_CNT = 7;
    localparam int GPIO_W = 5;
    localparam int SYNC_STAGES = 3;

    // register offsets
    localparam logic [ADDR_W-1:0] PERIPH_RESET_B_OFS = 12'h044;
    localparam logic [ADDR_W-1:0] GPIO_RESET_OFS = 12'h048;
    localparam logic [ADDR_W-1:0] RAW_STATUS_OFS = 12'h050;
    localparam logic [ADDR_W-1:0] EVENT_MASK_OFS = 12'h054;
    localparam logic [ADDR_W-1:0] MASKED_STATUS_OFS = 12'h058;

    // peripheral reset bit positions
    localparam int COMPARATOR_ZERO_BIT = 24;
    localparam int TIMER_TWO_BIT = 18;
    localparam int TIMER_ONE_BIT = 17;
    localparam int TIMER_ZERO_BIT = 16;
    localparam int I2C_BIT = 12;
    localparam int SYNC_SERIAL_BIT = 4;
    localparam int ASYNC_SERIAL_ONE_BIT = 1;
    localparam int ASYNC_SERIAL_ZERO_BIT = 0;

    // raw event bit positions
    localparam int PLL_LOCK_BIT = 6;
    localparam int CURRENT_LIMIT_BIT = 5;
    localparam int INT_OSC_FAULT_BIT = 4;
    localparam int MAIN_OSC_FAULT_BIT = 3;
    localparam int REGULATOR_UNREG_BIT = 2;
    localparam int BROWNOUT_BIT = 1;
    localparam int PLL_FAULT_BIT = 0;

    // implemented bits, everything else reads zero
    localparam logic [DATA_W-1:0] ONE_WORD = 32'h0000_0001;
    localparam logic [DATA_W-1:0] PERIPH_IMPL_MASK =
        (ONE_WORD << COMPARATOR_ZERO_BIT) | (ONE_WORD << TIMER_TWO_BIT) |
        (ONE_WORD << TIMER_ONE_BIT) | (ONE_WORD << TIMER_ZERO_BIT) |
        (ONE_WORD << I2C_BIT) | (ONE_WORD << SYNC_SERIAL_BIT) |
        (ONE_WORD << ASYNC_SERIAL_ONE_BIT) | (ONE_WORD << ASYNC_SERIAL_ZERO_BIT);
    localparam logic [DATA_W-1:0] GPIO_IMPL_MASK = (ONE_WORD << GPIO_W) - ONE_WORD;

    // reset values
    localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;
    localparam logic [EVENT_CNT-1:0] EVENT_RESET = 7'h00;
    localparam logic [EVENT_CNT-1:0] BROWNOUT_ONLY = 7'h01 << BROWNOUT_BIT;
endpackage : sysctl_pkg

//--- src/sysctl_reset_and_raw_status.sv
// software peripheral resets, raw event status, mask and masked status
`timescale 1ns/10ps
// Function
// - writes to peripheral reset register only touch bits present in capability two
// - writes to port reset register only touch bits present in capability four
// - comparator zero reset bit 24, read-write, resets to zero
// - timer two, one, zero reset bits 18, 17, 16, reset zero
// - I2C reset bit 12 and sync serial reset bit 4, reset zero
// - async serial one bit 1, zero bit 0, reset zero
// - port E..A reset bits 4..0; bits 31:5 reserved
// - raw status is read-only, resets to zero, hardware sets it
// - PLL lock raw bit 6 sets when PLL ready timer asserts
// - current limit raw bit 5 sets on regulator current limit event
// - internal oscillator fault bit 4, main oscillator fault bit 3
// - regulator unregulated raw bit 2 sets while output unregulated
// - brown-out raw bit 1 sets on any brown-out condition
// - brown-out interrupts only with mask set and reset-select clear
// - PLL fault raw bit 0 sets when PLL stops oscillating
// - masked status is raw AND mask; write one clears it and raw
// - each set mask bit raises interrupt while its raw bit is set
// - reset-select set makes brown-out raise reset, else interrupt
// - capability bit one means unit present and enables its reset bit
module sysctl_reset_and_raw_status
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [sysctl_pkg::ADDR_W-1:0] ADDR,
    input wire logic [sysctl_pkg::DATA_W-1:0] WDATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output logic [sysctl_pkg::DATA_W-1:0] RDATA,
    input wire logic [sysctl_pkg::DATA_W-1:0] CAPABILITY_REG_TWO,
    input wire logic [sysctl_pkg::DATA_W-1:0] CAPABILITY_REG_FOUR,
    input wire logic BROWNOUT_RESET_SELECT,
    input wire logic PLL_READY,
    input wire logic CURRENT_LIMIT,
    input wire logic INT_OSC_FAULT,
    input wire logic MAIN_OSC_FAULT,
    input wire logic REGULATOR_UNREG,
    input wire logic BROWNOUT_DETECT,
    input wire logic PLL_STOPPED,
    output logic [sysctl_pkg::DATA_W-1:0] PERIPH_RESETS,
    output logic [sysctl_pkg::GPIO_W-1:0] PORT_RESETS,
    output logic SYS_IRQ,
    output logic BROWNOUT_RESET_REQ
);
    import sysctl_pkg::*;

    logic [DATA_W-1:0] periph_reg;
    logic [DATA_W-1:0] periph_next;
    logic [DATA_W-1:0] gpio_reg;
    logic [DATA_W-1:0] gpio_next;
    logic [EVENT_CNT-1:0] raw_reg;
    logic [EVENT_CNT-1:0] raw_next;
    logic [EVENT_CNT-1:0] mask_reg;
    logic [EVENT_CNT-1:0] mask_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic irq_reg;
    logic irq_next;
    logic bor_rst_reg;
    logic bor_rst_next;
    logic [EVENT_CNT-1:0] event_pins;
    logic [EVENT_CNT-1:0] event_level;
    logic [EVENT_CNT-1:0] clear_bits;
    logic [EVENT_CNT-1:0] irq_gate;
    logic wr_periph;
    logic wr_gpio;
    logic wr_mask;
    logic wr_masked;

    // gather event pins in raw status order
    always_comb
    begin
        event_pins = EVENT_RESET;
        event_pins[PLL_LOCK_BIT] = PLL_READY;
        event_pins[CURRENT_LIMIT_BIT] = CURRENT_LIMIT;
        event_pins[INT_OSC_FAULT_BIT] = INT_OSC_FAULT;
        event_pins[MAIN_OSC_FAULT_BIT] = MAIN_OSC_FAULT;
        event_pins[REGULATOR_UNREG_BIT] = REGULATOR_UNREG;
        event_pins[BROWNOUT_BIT] = BROWNOUT_DETECT;
        event_pins[PLL_FAULT_BIT] = PLL_STOPPED;
    end

    // one synchroniser per event line
    genvar gi;
    generate
        for (gi = 0; gi < EVENT_CNT; gi++)
        begin : g_event
            event_sync_if ev_bus ();
            assign ev_bus.raw_level = event_pins[gi];
            assign event_level[gi] = ev_bus.filtered;
            event_filter u_filter
            (
                .CLK_SYS (CLK_SYS),
                .RST (RST),
                .ev (ev_bus.filter)
            );
        end
    endgenerate

    // write decode
    assign wr_periph = WR_STB && (ADDR == PERIPH_RESET_B_OFS);
    assign wr_gpio = WR_STB && (ADDR == GPIO_RESET_OFS);
    assign wr_mask = WR_STB && (ADDR == EVENT_MASK_OFS);
    assign wr_masked = WR_STB && (ADDR == MASKED_STATUS_OFS);

    // brown-out only reaches the interrupt when reset-select is clear
    always_comb
    begin
        irq_gate = {EVENT_CNT{1'b1}};
        irq_gate[BROWNOUT_BIT] = ~BROWNOUT_RESET_SELECT;
    end

    // next state of reset controls, status, mask and outputs
    always_comb
    begin
        periph_next = periph_reg;
        gpio_next = gpio_reg;
        mask_next = mask_reg;
        clear_bits = EVENT_RESET;
        if (wr_periph)
        begin
            // present units take the write, the rest keep their value
            periph_next = ((WDATA & CAPABILITY_REG_TWO) | (periph_reg & ~CAPABILITY_REG_TWO))
                & PERIPH_IMPL_MASK;
        end
        if (wr_gpio)
        begin
            gpio_next = ((WDATA & CAPABILITY_REG_FOUR) | (gpio_reg & ~CAPABILITY_REG_FOUR))
                & GPIO_IMPL_MASK;
        end
        if (wr_mask)
        begin
            mask_next = WDATA[EVENT_CNT-1:0];
        end
        if (wr_masked)
        begin
            clear_bits = WDATA[EVENT_CNT-1:0];
        end
        // a new event beats a clear in the same cycle
        raw_next = (raw_reg & ~clear_bits) | event_level;
        irq_next = |(raw_reg & mask_reg & irq_gate);
        bor_rst_next = raw_reg[BROWNOUT_BIT] & BROWNOUT_RESET_SELECT;
    end

    // read mux, data valid only in the cycle after the strobe
    always_comb
    begin
        rdata_next = WORD_RESET;
        if (RD_STB)
        begin
            unique case (ADDR)
                PERIPH_RESET_B_OFS: rdata_next = periph_reg;
                GPIO_RESET_OFS: rdata_next = gpio_reg;
                RAW_STATUS_OFS: rdata_next = {{(DATA_W-EVENT_CNT){1'b0}}, raw_reg};
                EVENT_MASK_OFS: rdata_next = {{(DATA_W-EVENT_CNT){1'b0}}, mask_reg};
                MASKED_STATUS_OFS:
                    rdata_next = {{(DATA_W-EVENT_CNT){1'b0}}, raw_reg & mask_reg};
                default: rdata_next = WORD_RESET;
            endcase
        end
    end

    // registers
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            periph_reg <= WORD_RESET;
            gpio_reg <= WORD_RESET;
            raw_reg <= EVENT_RESET;
            mask_reg <= EVENT_RESET;
            rdata_reg <= WORD_RESET;
            irq_reg <= 1'b0;
            bor_rst_reg <= 1'b0;
        end
        else
        begin
            periph_reg <= periph_next;
            gpio_reg <= gpio_next;
            raw_reg <= raw_next;
            mask_reg <= mask_next;
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
            bor_rst_reg <= bor_rst_next;
        end
    end

    // outputs straight from flops; reset bits hold peripherals in reset
    assign RDATA = rdata_reg;
    assign PERIPH_RESETS = periph_reg;
    assign PORT_RESETS = gpio_reg[GPIO_W-1:0];
    assign SYS_IRQ = irq_reg;
    assign BROWNOUT_RESET_REQ = bor_rst_reg;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    sequence s_read_raw;
        RD_STB && (ADDR == RAW_STATUS_OFS);
    endsequence

    sequence s_clear_write;
        wr_masked && (WDATA[EVENT_CNT-1:0] != EVENT_RESET);
    endsequence

    property p_periph_write_masked;
        wr_periph |=> periph_reg == ((($past(WDATA) & $past(CAPABILITY_REG_TWO))
            | ($past(periph_reg) & ~$past(CAPABILITY_REG_TWO))) & PERIPH_IMPL_MASK);
    endproperty
    a_periph_write_masked: assert property (p_periph_write_masked)
        else $error("peripheral reset write not masked by capability");

    property p_gpio_write_masked;
        wr_gpio |=> gpio_reg == ((($past(WDATA) & $past(CAPABILITY_REG_FOUR))
            | ($past(gpio_reg) & ~$past(CAPABILITY_REG_FOUR))) & GPIO_IMPL_MASK);
    endproperty
    a_gpio_write_masked: assert property (p_gpio_write_masked)
        else $error("port reset write not masked by capability");

    property p_periph_fields;
        (periph_reg & ~PERIPH_IMPL_MASK) == WORD_RESET;
    endproperty
    a_periph_fields: assert property (p_periph_fields)
        else $error("unimplemented peripheral reset bit set");

    property p_gpio_fields;
        (gpio_reg & ~GPIO_IMPL_MASK) == WORD_RESET;
    endproperty
    a_gpio_fields: assert property (p_gpio_fields)
        else $error("reserved port reset bit set");

    property p_event_sets_raw;
        (event_level != EVENT_RESET) |=> (raw_reg & $past(event_level)) == $past(event_level);
    endproperty
    a_event_sets_raw: assert property (p_event_sets_raw)
        else $error("raw status missed an event");

    property p_raw_sticky;
        !wr_masked |=> (raw_reg & $past(raw_reg)) == $past(raw_reg);
    endproperty
    a_raw_sticky: assert property (p_raw_sticky)
        else $error("raw status lost a bit without a clear");

    property p_clear_raw;
        s_clear_write ##0 ((WDATA[EVENT_CNT-1:0] & event_level) == EVENT_RESET)
            |=> (raw_reg & $past(WDATA[EVENT_CNT-1:0])) == EVENT_RESET;
    endproperty
    a_clear_raw: assert property (p_clear_raw)
        else $error("write one did not clear raw status");

    property p_irq_follows;
        ##1 SYS_IRQ == |($past(raw_reg) & $past(mask_reg) & $past(irq_gate));
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("interrupt does not follow masked status");

    property p_bor_no_irq;
        (BROWNOUT_RESET_SELECT && ((raw_reg & mask_reg & ~BROWNOUT_ONLY) == EVENT_RESET))
            |=> !SYS_IRQ;
    endproperty
    a_bor_no_irq: assert property (p_bor_no_irq)
        else $error("brown-out interrupted while reset selected");

    property p_bor_reset;
        (raw_reg[BROWNOUT_BIT] && BROWNOUT_RESET_SELECT) |=> BROWNOUT_RESET_REQ;
    endproperty
    a_bor_reset: assert property (p_bor_reset)
        else $error("brown-out reset request missing");

    property p_read_raw;
        s_read_raw |=> RDATA == {{(DATA_W-EVENT_CNT){1'b0}}, $past(raw_reg)} ##1 RDATA == WORD_RESET
            || $past(RD_STB);
    endproperty
    a_read_raw: assert property (p_read_raw)
        else $error("raw status read returned wrong data");

    // reset controls only move on a write to their own offset
    property p_periph_hold;
        !wr_periph |=> periph_reg == $past(periph_reg);
    endproperty
    a_periph_hold: assert property (p_periph_hold)
        else $error("peripheral reset bit changed without a write");

    property p_gpio_hold;
        !wr_gpio |=> gpio_reg == $past(gpio_reg);
    endproperty
    a_gpio_hold: assert property (p_gpio_hold)
        else $error("port reset bit changed without a write");

    // masked status read shows raw and mask together
    sequence s_read_masked;
        RD_STB && (ADDR == MASKED_STATUS_OFS);
    endsequence

    property p_read_masked;
        s_read_masked |=> RDATA == {{(DATA_W-EVENT_CNT){1'b0}}, $past(raw_reg) & $past(mask_reg)};
    endproperty
    a_read_masked: assert property (p_read_masked)
        else $error("masked status read returned wrong data");
endmodule : sysctl_reset_and_raw_status

//--- test/sysctl_reset_and_raw_status_tb_top.sv
// self-checking bench for the peripheral reset and raw event status block
`timescale 1ns/10ps
module sysctl_reset_and_raw_status_tb_top;
    import sysctl_pkg::*;
    typedef struct {logic [1:0] sel; logic [DATA_W-1:0] val;} note_type;
    logic clk_sys, rst, wr_stb, rd_stb, bro_sel, probe, rd_d;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, cap_two, cap_four, rdata, periph_resets, got, e_per, w, m;
    logic [GPIO_W-1:0] port_resets;
    logic [EVENT_CNT-1:0] ev;
    logic sys_irq, bro_req;
    note_type notes[$];
    note_type n;
    int mismatches, n_checks, b;
    int bits[8] = '{24, 18, 17, 16, 12, 4, 1, 0};

    sysctl_reset_and_raw_status uut (.CLK_SYS(clk_sys), .RST(rst), .ADDR(addr),
        .WDATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata),
        .CAPABILITY_REG_TWO(cap_two), .CAPABILITY_REG_FOUR(cap_four),
        .BROWNOUT_RESET_SELECT(bro_sel), .PLL_READY(ev[6]), .CURRENT_LIMIT(ev[5]),
        .INT_OSC_FAULT(ev[4]), .MAIN_OSC_FAULT(ev[3]), .REGULATOR_UNREG(ev[2]),
        .BROWNOUT_DETECT(ev[1]), .PLL_STOPPED(ev[0]), .PERIPH_RESETS(periph_resets),
        .PORT_RESETS(port_resets), .SYS_IRQ(sys_irq), .BROWNOUT_RESET_REQ(bro_req));

    // 50 MHz system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish

    task automatic wait_cycles(input int c);
        repeat (c) @(posedge clk_sys);
    endtask : wait_cycles

    // one-cycle register write
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        wr_stb <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
    endtask : wr

    // one-cycle read, expected word noted for the monitor
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        notes.push_back('{2'd0, e});
        @(posedge clk_sys);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
    endtask : rd

    // note an expected output level: 1 resets, 2 ports, 3 irq and reset request
    task automatic look(input logic [1:0] s, input logic [DATA_W-1:0] e);
        notes.push_back('{s, e});
        @(posedge clk_sys);
        probe <= 1'b1;
        @(posedge clk_sys);
        probe <= 1'b0;
    endtask : look

    // bounded wait for all notes to be compared
    task automatic drain();
        int k;
        for (k = 0; k < 20 && notes.size() > 0; k++)
            @(posedge clk_sys);
        if (notes.size() > 0)
        begin
            mismatches++;
            tally_and_finish();
        end
    endtask : drain

    // monitor: takes the oldest note whenever a result appears
    always @(posedge clk_sys)
    begin
        rd_d <= rd_stb;
        if (rd_d || probe)
        begin
            n = notes.pop_front();
            case (n.sel)
                2'd0: got = rdata;
                2'd1: got = periph_resets;
                2'd2: got = {27'h0, port_resets};
                default: got = {30'h0, sys_irq, bro_req};
            endcase
            n_checks++;
            if (got !== n.val)
            begin
                mismatches++;
                $display("mismatch at %0t: got %h expected %h", $time, got, n.val);
            end
        end
    end

    initial
    begin
        {rst, wr_stb, rd_stb, bro_sel, probe} = 5'b10000;
        {addr, wdata, ev} = '0;
        cap_two = 32'hFFFF_FFFF;
        cap_four = 32'hFFFF_FFFF;
        mismatches = 0;
        n_checks = 0;
        void'($urandom(32'h51ED7A18));
        wait_cycles(16);
        rst <= 1'b0;
        // reset values and read-only raw status
        rd(PERIPH_RESET_B_OFS, WORD_RESET);
        rd(GPIO_RESET_OFS, WORD_RESET);
        wr(RAW_STATUS_OFS, 32'h0000_007F);
        rd(RAW_STATUS_OFS, WORD_RESET);
        look(2'd3, 32'h0);
        // each named reset bit alone, mirrored on the reset outputs
        foreach (bits[i])
        begin
            wr(PERIPH_RESET_B_OFS, ONE_WORD << bits[i]);
            rd(PERIPH_RESET_B_OFS, ONE_WORD << bits[i]);
            look(2'd1, ONE_WORD << bits[i]);
        end
        for (int k = 0; k < GPIO_W; k++)
        begin
            wr(GPIO_RESET_OFS, ONE_WORD << k);
            rd(GPIO_RESET_OFS, ONE_WORD << k);
            look(2'd2, ONE_WORD << k);
        end
        // writes masked by random presence bits; reserved bits left alone
        e_per = WORD_RESET;
        wr(PERIPH_RESET_B_OFS, e_per);
        w = WORD_RESET;
        wr(GPIO_RESET_OFS, w);
        for (int k = 0; k < 6; k++)
        begin
            cap_two <= $urandom();
            cap_four <= $urandom();
            @(posedge clk_sys);
            m = $urandom() & PERIPH_IMPL_MASK;
            e_per = (e_per & ~cap_two) | (m & cap_two);
            wr(PERIPH_RESET_B_OFS, m);
            rd(PERIPH_RESET_B_OFS, e_per);
            look(2'd1, e_per);
            m = $urandom() & GPIO_IMPL_MASK;
            w = (w & ~cap_four) | (m & cap_four);
            wr(GPIO_RESET_OFS, m);
            rd(GPIO_RESET_OFS, w);
            look(2'd2, w);
        end
        // unmapped access is ignored and reads zero
        wr(12'h04C, 32'hFFFF_FFFF);
        rd(12'h04C, WORD_RESET);
        rd(PERIPH_RESET_B_OFS, e_per);
        // every event, brown-out once more with reset-select set
        for (int j = 0; j < 8; j++)
        begin
            b = (j == 7) ? BROWNOUT_BIT : j;
            bro_sel <= (j == 7);
            ev <= 7'h01 << b;
            wait_cycles(8);
            rd(RAW_STATUS_OFS, ONE_WORD << b);
            look(2'd3, (j == 7) ? 32'h1 : 32'h0);
            wr(EVENT_MASK_OFS, ONE_WORD << b);
            rd(EVENT_MASK_OFS, ONE_WORD << b);
            wait_cycles(3);
            look(2'd3, (j == 7) ? 32'h1 : 32'h2);
            rd(MASKED_STATUS_OFS, ONE_WORD << b);
            wr(MASKED_STATUS_OFS, ONE_WORD << b);
            rd(RAW_STATUS_OFS, ONE_WORD << b);
            ev <= EVENT_RESET;
            wait_cycles(8);
            wr(MASKED_STATUS_OFS, ONE_WORD << b);
            rd(RAW_STATUS_OFS, WORD_RESET);
            look(2'd3, 32'h0);
            wr(EVENT_MASK_OFS, WORD_RESET);
        end
        // second reset in mid-run clears everything
        drain();
        rst <= 1'b1;
        wait_cycles(4);
        rst <= 1'b0;
        rd(PERIPH_RESET_B_OFS, WORD_RESET);
        rd(GPIO_RESET_OFS, WORD_RESET);
        look(2'd1, WORD_RESET);
        rd(RAW_STATUS_OFS, WORD_RESET);
        drain();
        tally_and_finish();
    end
endmodule : sysctl_reset_and_raw_status_tb_top
